// [hw/psf_flash_seq.sv]
`timescale 1ns/1ps
module psf_flash_seq
  import psf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Core table instruction port
  input  wire logic        tbl_req,
  input  wire logic        tbl_write,
  input  wire logic        tbl_high,
  input  wire logic        tbl_byte,
  input  wire logic [15:0] tbl_ea,
  input  wire logic [15:0] tbl_wdata,
  output logic [15:0]      tbl_rdata,
  output logic             tbl_cfg,
  // Program-space window into data space
  input  wire logic        win_req,
  input  wire logic        win_write,
  input  wire logic [23:0] win_addr,
  output logic [15:0]      win_rdata,
  output logic             win_err,
  // Core stall
  output logic             core_stall
);
  localparam int WORDS = 4096;
  localparam int AW    = 12;
  // Array is 24 bits wide; word index is address/2
  logic [23:0] mem [WORDS];
  logic [7:0]  table_page_register;
  logic [7:0]  target_address_upper;
  logic [15:0] target_address_lower;
  logic        start_reg, wren_reg, err_reg;
  logic [3:0]  op_reg;
  logic [23:0] latch0_reg, latch1_reg;
  psf_seq_t    seq_reg;
  logic [15:0] cnt_reg;
  logic [23:0] op_addr_reg;
  logic [AW-1:0] wipe_reg;
  // Bus address phase capture
  logic        dph_reg, dwr_reg;
  logic [7:0]  dofs_reg;
  wire  take   = hsel && hready && htrans == PSF_HTRANS_NONSEQ;
  wire  bus_wr = dph_reg && dwr_reg;
  wire  w_ctrl = bus_wr && dofs_reg == PSF_OFS_CTRL;
  wire  w_key  = bus_wr && dofs_reg == PSF_OFS_KEY;
  wire  w_adru = bus_wr && dofs_reg == PSF_OFS_ADRU;
  wire  w_adrl = bus_wr && dofs_reg == PSF_OFS_ADRL;
  wire  w_page = bus_wr && dofs_reg == PSF_OFS_TABLE_PAGE_REGISTER;
  wire  busy   = seq_reg != PSF_SQ_IDLE;
  wire  unlocked;
  wire  start_req = w_ctrl && hwdata[PSF_CTRL_START] && !busy;
  wire  op_ok = op_reg == PSF_OP_ERASE || op_reg == PSF_OP_PROG2;
  wire  [3:0] op_new = hwdata[PSF_OP_HI:0];
  wire  op_new_ok = op_new == PSF_OP_ERASE || op_new == PSF_OP_PROG2;
  wire  launch = start_req && unlocked && hwdata[PSF_CTRL_WREN] && op_new_ok;
  wire  refuse = start_req && !launch;
  wire  [23:0] tgt = {target_address_upper, target_address_lower};
  // Table mapping
  wire  [23:0] tbl_paddr;
  wire  [15:0] tbl_map;
  wire  [AW-1:0] tidx = tbl_paddr[AW:1];
  psf_table_map u_map (
    .table_page_register (table_page_register),
    .ea                  (tbl_ea),
    .high_sel            (tbl_high),
    .byte_mode           (tbl_byte),
    .pword               (mem[tidx]),
    .paddr               (tbl_paddr),
    .cfg_space           (tbl_cfg),
    .rdata               (tbl_map)
  );
  psf_unlock u_key (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wr_any   (bus_wr),
    .wr_key   (w_key),
    .key_data (hwdata[7:0]),
    .consume  (w_ctrl),
    .unlocked (unlocked)
  );
  // Table writes land in the two-word latch, selected by address bit 1
  wire        tw    = tbl_req && tbl_write && !busy;
  wire        tslot = tbl_ea[1];
  wire [23:0] tlat  = tslot ? latch1_reg : latch0_reg;
  wire        bsel  = tbl_ea[0];
  wire [23:0] lo_upd = !tbl_byte ? {tlat[23:16], tbl_wdata} :
                       bsel ? {tlat[23:16], tbl_wdata[7:0], tlat[7:0]} :
                              {tlat[23:8], tbl_wdata[7:0]};
  wire [23:0] hi_upd = (tbl_byte && bsel) ? tlat : {tbl_wdata[7:0], tlat[15:0]};
  wire [23:0] tw_val = tbl_high ? hi_upd : lo_upd;
  // Read mux follows the address phase so data stands through the data phase
  wire [7:0]  rofs    = haddr[7:0];
  wire [15:0] ctrl_rd = {start_reg, wren_reg, err_reg, 9'h000, op_reg};
  wire [31:0] rd_mux =
      rofs == PSF_OFS_CTRL   ? {16'h0000, ctrl_rd} :
      rofs == PSF_OFS_ADRU   ? {24'h000000, target_address_upper} :
      rofs == PSF_OFS_ADRL   ? {16'h0000, target_address_lower} :
      rofs == PSF_OFS_TABLE_PAGE_REGISTER ? {24'h000000, table_page_register} :
      rofs == PSF_OFS_LATL   ? {8'h00, latch0_reg} :
      rofs == PSF_OFS_LATH   ? {8'h00, latch1_reg} :
      rofs == PSF_OFS_STAT   ? {30'h00000000, unlocked, busy} : 32'h00000000;
  // Erase walks the page two words a cycle; program writes two words
  wire [AW-1:0] page_base = {op_addr_reg[AW:PSF_PAGE_ABITS], {(PSF_PAGE_ABITS-1){1'b0}}};
  wire [AW-1:0] pidx      = {op_addr_reg[AW:2], 1'b0};
  wire          cnt_done  = cnt_reg == 16'h0000;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign core_stall = busy;
  assign win_err    = win_req && win_write;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dph_reg  <= 1'b0;
      dwr_reg  <= 1'b0;
      dofs_reg <= 8'h00;
      hrdata   <= 32'h00000000;
    end else begin
      dph_reg  <= take;
      dwr_reg  <= take && hwrite && hsize == PSF_HSIZE_WORD;
      dofs_reg <= haddr[7:0];
      // A read right behind a write to the same register sees the old value
      if (take && !hwrite) hrdata <= rd_mux;
    end
  end
  // Bus read data registered in the address phase; rd_mux uses the live haddr offset, not the captured one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tbl_rdata <= 16'h0000;
      win_rdata <= 16'h0000;
    end else begin
      if (tbl_req && !tbl_write) tbl_rdata <= tbl_map;
      if (win_req && !win_write) win_rdata <= mem[win_addr[AW:1]][15:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      table_page_register  <= 8'h00;
      target_address_upper <= 8'h00;
      target_address_lower <= 16'h0000;
      wren_reg <= 1'b0;
      err_reg  <= 1'b0;
      op_reg   <= 4'h0;
    end else begin
      if (w_page) table_page_register  <= hwdata[7:0];
      if (w_adru && !busy) target_address_upper <= hwdata[7:0];
      if (w_adrl && !busy) target_address_lower <= hwdata[15:0];
      if (w_ctrl && !busy) begin
        wren_reg <= hwdata[PSF_CTRL_WREN];
        op_reg   <= op_new;
        err_reg  <= hwdata[PSF_CTRL_ERR] | refuse;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      latch0_reg <= 24'hffffff;
      latch1_reg <= 24'hffffff;
    end else if (tw) begin
      if (tslot) latch1_reg <= tw_val;
      else       latch0_reg <= tw_val;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq_reg     <= PSF_SQ_IDLE;
      start_reg   <= 1'b0;
      cnt_reg     <= 16'h0000;
      op_addr_reg <= 24'h000000;
      wipe_reg    <= '0;
    end else begin
      case (seq_reg)
        PSF_SQ_IDLE: begin
          if (launch) begin
            start_reg   <= 1'b1;
            op_addr_reg <= tgt;
            wipe_reg    <= '0;
            if (op_new == PSF_OP_ERASE) begin
              seq_reg <= PSF_SQ_ERASE;
              cnt_reg <= PSF_ERASE_CYC16;
            end else begin
              seq_reg <= PSF_SQ_PROG;
              cnt_reg <= PSF_PROG_CYC16;
            end
          end
        end
        PSF_SQ_ERASE: begin
          // Two words a cycle so the whole page is wiped before the count ends
          if (wipe_reg != AW'(PSF_PAGE_WORDS / 2 - 1)) wipe_reg <= wipe_reg + 1'b1;
          mem[page_base + {wipe_reg[AW-2:0], 1'b0}] <= 24'hffffff;
          mem[page_base + {wipe_reg[AW-2:0], 1'b1}] <= 24'hffffff;
          if (cnt_done) begin
            seq_reg   <= PSF_SQ_IDLE;
            start_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        PSF_SQ_PROG: begin
          if (cnt_done) begin
            mem[pidx]      <= latch0_reg;
            mem[pidx + 1'b1] <= latch1_reg;
            seq_reg   <= PSF_SQ_IDLE;
            start_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: seq_reg <= PSF_SQ_IDLE;
      endcase
    end
  end
endmodule

// [hw/psf_pkg.sv]
package psf_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] PSF_OFS_CTRL   = 8'h00;
  localparam logic [7:0] PSF_OFS_KEY    = 8'h04;
  localparam logic [7:0] PSF_OFS_ADRU   = 8'h08;
  localparam logic [7:0] PSF_OFS_ADRL   = 8'h0c;
  localparam logic [7:0] PSF_OFS_TABLE_PAGE_REGISTER = 8'h10;
  localparam logic [7:0] PSF_OFS_LATL   = 8'h14;
  localparam logic [7:0] PSF_OFS_LATH   = 8'h18;
  localparam logic [7:0] PSF_OFS_STAT   = 8'h1c;
  // Control register fields
  localparam int PSF_CTRL_START = 15;
  localparam int PSF_CTRL_WREN  = 14;
  localparam int PSF_CTRL_ERR   = 13;
  localparam int PSF_OP_HI      = 3;
  // Operation select codes
  localparam logic [3:0] PSF_OP_PROG2 = 4'h1;
  localparam logic [3:0] PSF_OP_ERASE = 4'h3;
  // Unlock key values
  localparam logic [7:0] PSF_KEY_FIRST  = 8'h55;
  localparam logic [7:0] PSF_KEY_SECOND = 8'haa;
  // Widths
  localparam int PSF_PW = 24;
  localparam int PSF_DW = 16;
  localparam int PSF_PAGE_CFG_BIT = 7;
  // Page of 1024 words; word addresses step by two, so page spans 2048 addresses
  localparam int PSF_PAGE_WORDS = 1024;
  localparam int PSF_PAGE_ABITS = 11;
  localparam int PSF_PROG_WORDS = 2;
  // Self-timed operation lengths in microseconds, and cycle counts at 50 MHz
  localparam int PSF_CLK_MHZ      = 50;
  localparam int PSF_ERASE_US     = 20;
  localparam int PSF_PROG_US      = 10;
  localparam int PSF_ERASE_CYC    = PSF_ERASE_US * PSF_CLK_MHZ;
  localparam int PSF_PROG_CYC     = PSF_PROG_US * PSF_CLK_MHZ;
  localparam logic [15:0] PSF_ERASE_CYC16 = 16'(PSF_ERASE_CYC);
  localparam logic [15:0] PSF_PROG_CYC16  = 16'(PSF_PROG_CYC);
  // AHB codes
  localparam logic [1:0] PSF_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] PSF_HSIZE_WORD    = 3'b010;
  typedef enum logic [1:0] {
    PSF_KEY_IDLE = 2'b00,
    PSF_KEY_GOT1 = 2'b01,
    PSF_KEY_OPEN = 2'b10
  } psf_key_t;
  typedef enum logic [1:0] {
    PSF_SQ_IDLE  = 2'b00,
    PSF_SQ_ERASE = 2'b01,
    PSF_SQ_PROG  = 2'b10
  } psf_seq_t;
endpackage

// [hw/psf_table_map.sv]
`timescale 1ns/1ps
module psf_table_map
  import psf_pkg::*;
(
  // Table access request
  input  wire logic [7:0]  table_page_register,
  input  wire logic [15:0] ea,
  input  wire logic        high_sel,
  input  wire logic        byte_mode,
  // Program word from array
  input  wire logic [23:0] pword,
  // Results
  output logic [23:0]      paddr,
  output logic             cfg_space,
  output logic [15:0]      rdata
);
  wire       bsel = ea[0];
  wire [7:0] lo_b = bsel ? pword[15:8] : pword[7:0];
  wire [7:0] hi_b = bsel ? 8'h00 : pword[23:16];
  wire [15:0] lo_r = byte_mode ? {8'h00, lo_b} : pword[15:0];
  wire [15:0] hi_r = byte_mode ? {8'h00, hi_b} : {8'h00, pword[23:16]};
  assign paddr     = {table_page_register, ea};
  assign cfg_space = table_page_register[PSF_PAGE_CFG_BIT];
  assign rdata     = high_sel ? hi_r : lo_r;
endmodule

// [hw/psf_unlock.sv]
`timescale 1ns/1ps
module psf_unlock
  import psf_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Register writes seen on the bus
  input  wire logic       wr_any,
  input  wire logic       wr_key,
  input  wire logic [7:0] key_data,
  input  wire logic       consume,
  // Armed once 0x55 then 0xaa were written back to back
  output logic            unlocked
);
  psf_key_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    if (wr_any) begin
      case (st_reg)
        PSF_KEY_IDLE: st_next = (wr_key && key_data == PSF_KEY_FIRST) ? PSF_KEY_GOT1
                                                                     : PSF_KEY_IDLE;
        PSF_KEY_GOT1: st_next = (wr_key && key_data == PSF_KEY_SECOND) ? PSF_KEY_OPEN
                                                                      : PSF_KEY_IDLE;
        PSF_KEY_OPEN: st_next = PSF_KEY_IDLE;
        default:      st_next = PSF_KEY_IDLE;
      endcase
    end
    if (consume) st_next = PSF_KEY_IDLE;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) st_reg <= PSF_KEY_IDLE;
    else     st_reg <= st_next;
  end
  assign unlocked = (st_reg == PSF_KEY_OPEN);
endmodule

// [sim/psf_flash_seq_checker.sv]
`timescale 1ns/1ps
module psf_flash_seq_checker
  import psf_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Bus answer
  input wire logic        hreadyout,
  // Table port
  input wire logic        tbl_req,
  input wire logic        tbl_write,
  input wire logic [15:0] tbl_rdata,
  // Window and stall
  input wire logic        win_req,
  input wire logic        win_write,
  input wire logic [15:0] win_rdata,
  input wire logic        win_err,
  input wire logic        core_stall
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [11:0] stall_cnt;
  // Length of the current stall, cleared between operations
  always_ff @(posedge clk_sys) begin
    stall_cnt <= (rst || !core_stall) ? 12'h000 : stall_cnt + 12'h001;
  end
  chk_win_refuse: assert property (win_req && win_write |-> win_err)
    else $error("window write not flagged");
  chk_win_quiet: assert property (!(win_req && win_write) |-> !win_err)
    else $error("window error without write");
  chk_win_hold: assert property (!$past(win_req && !win_write) |-> $stable(win_rdata))
    else $error("window data moved without read");
  chk_tbl_hold: assert property (!$past(tbl_req && !tbl_write) |-> $stable(tbl_rdata))
    else $error("table data moved without read");
  chk_stall_min: assert property ($rose(core_stall) |-> core_stall [*8])
    else $error("stall too short");
  chk_stall_max: assert property (int'(stall_cnt) <= PSF_ERASE_CYC + 2)
    else $error("stall too long");
  chk_stall_ends: assert property ($fell(core_stall) |-> int'(stall_cnt) >= PSF_PROG_CYC)
    else $error("operation ended early");
  chk_ready_high: assert property (hreadyout)
    else $error("bus stalled instead of core");
  cover property ($rose(core_stall));
  cover property (win_req && win_write);
  cover property (tbl_req && !tbl_write);
endmodule

// [sim/psf_core_model.sv]
`timescale 1ns/1ps
module psf_core_model
  import psf_pkg::*;
(
  // Clock
  input wire logic        clk_sys,
  // Table port
  output logic            tbl_req = 1'b0,
  output logic            tbl_write = 1'b0,
  output logic            tbl_high = 1'b0,
  output logic            tbl_byte = 1'b0,
  output logic [15:0]     tbl_ea = 16'h0,
  output logic [15:0]     tbl_wdata = 16'h0,
  input wire logic [15:0] tbl_rdata,
  // Window and stall
  output logic            win_req = 1'b0,
  output logic            win_write = 1'b0,
  output logic [23:0]     win_addr = 24'h0,
  input wire logic [15:0] win_rdata,
  input wire logic        core_stall
);
  task automatic tbl_op(input logic w, hi, by, input logic [15:0] ea, wd,
                        output logic [15:0] rd);
    @(posedge clk_sys);
    // Nothing issues while stalled, covering the slots after a start
    while (core_stall) @(posedge clk_sys);
    tbl_req <= 1'b1;
    tbl_write <= w;
    tbl_high <= hi;
    tbl_byte <= by;
    tbl_ea <= ea;
    tbl_wdata <= wd;
    @(posedge clk_sys);
    tbl_req <= 1'b0;
    // Released lines flip so stale values cannot pass
    tbl_ea <= ~ea;
    tbl_wdata <= ~wd;
    #1;
    rd = tbl_rdata;
  endtask
  task automatic win_op(input logic w, input logic [23:0] a, output logic [15:0] rd);
    @(posedge clk_sys);
    while (core_stall) @(posedge clk_sys);
    win_req <= 1'b1;
    win_write <= w;
    win_addr <= a;
    @(posedge clk_sys);
    win_req <= 1'b0;
    win_addr <= ~a;
    #1;
    rd = win_rdata;
  endtask
endmodule

// [sim/program_space_table_access_flash_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module program_space_table_access_flash_tb;
  import psf_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b000;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, tbl_req, tbl_write, tbl_high, tbl_byte, tbl_cfg;
  logic [15:0] tbl_ea, tbl_wdata, tbl_rdata, win_rdata;
  logic        win_req, win_write, win_err, core_stall;
  logic [23:0] win_addr;
  int          bad_count = 0;
  int          n_compared = 0;
  // Entries are {high, byte, address, expected}
  logic [33:0] rv [8] = '{{2'b00, 16'h0, 16'h1234}, {2'b01, 16'h0, 16'h0034},
    {2'b01, 16'h1, 16'h0012}, {2'b10, 16'h0, 16'h0056}, {2'b11, 16'h0, 16'h0056},
    {2'b11, 16'h1, 16'h0000}, {2'b00, 16'h2, 16'hbeef}, {2'b10, 16'h2, 16'h007a}};
  always #10 clk_sys = ~clk_sys;
  psf_flash_seq uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tbl_req(tbl_req),
    .tbl_write(tbl_write), .tbl_high(tbl_high), .tbl_byte(tbl_byte), .tbl_ea(tbl_ea),
    .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .tbl_cfg(tbl_cfg), .win_req(win_req),
    .win_write(win_write), .win_addr(win_addr), .win_rdata(win_rdata), .win_err(win_err),
    .core_stall(core_stall));
  psf_core_model core (.clk_sys(clk_sys), .tbl_req(tbl_req), .tbl_write(tbl_write),
    .tbl_high(tbl_high), .tbl_byte(tbl_byte), .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata),
    .tbl_rdata(tbl_rdata), .win_req(win_req), .win_write(win_write), .win_addr(win_addr),
    .win_rdata(win_rdata), .core_stall(core_stall));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= PSF_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= PSF_HSIZE_WORD;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    r = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic run_op(input logic [3:0] op, output int cyc);
    int k;
    wr(PSF_OFS_KEY, 32'h55);
    wr(PSF_OFS_KEY, 32'haa);
    wr(PSF_OFS_CTRL, 32'h0000c000 | {28'h0, op});
    cyc = 0;
    for (k = 0; k < 3000 && (cyc == 0 || core_stall === 1'b1); k++) begin
      @(negedge clk_sys);
      if (core_stall === 1'b1) cyc++;
    end
  endtask
  task automatic t_regs;
    logic [31:0] r;
    wr(PSF_OFS_ADRU, 32'h0);
    wr(PSF_OFS_ADRL, 32'h2);
    wr(PSF_OFS_TABLE_PAGE_REGISTER, 32'h0);
    bus(1'b0, PSF_OFS_ADRL, 32'h0, r);
    `CHK(r, 32'h2)
    bus(1'b0, PSF_OFS_KEY, 32'h0, r);
    `CHK(r, 32'h0)
    bus(1'b0, 8'h20, 32'h0, r);
    `CHK(r, 32'h0)
    $display("test regs done");
  endtask
  task automatic t_refuse;
    logic [31:0] r;
    wr(PSF_OFS_CTRL, 32'hc003);
    bus(1'b0, PSF_OFS_CTRL, 32'h0, r);
    `CHK({r[15], r[13]}, 2'b01)
    wr(PSF_OFS_KEY, 32'h55);
    wr(PSF_OFS_ADRL, 32'h2);
    wr(PSF_OFS_KEY, 32'haa);
    wr(PSF_OFS_CTRL, 32'hc003);
    bus(1'b0, PSF_OFS_STAT, 32'h0, r);
    `CHK({r[0], core_stall}, 2'b00)
    $display("test refuse done");
  endtask
  task automatic t_flash;
    logic [31:0] r;
    logic [15:0] d;
    int          c;
    // The page is erased before it is programmed
    run_op(PSF_OP_ERASE, c);
    `CHK(c >= PSF_ERASE_CYC && c <= PSF_ERASE_CYC + 2, 1'b1)
    bus(1'b0, PSF_OFS_CTRL, 32'h0, r);
    `CHK(r[15], 1'b0)
    core.tbl_op(1'b0, 1'b0, 1'b0, 16'h07fe, 16'h0, d);
    `CHK(d, 16'hffff)
    core.tbl_op(1'b1, 1'b0, 1'b0, 16'h0, 16'h1234, d);
    core.tbl_op(1'b1, 1'b1, 1'b0, 16'h0, 16'h0056, d);
    core.tbl_op(1'b1, 1'b0, 1'b0, 16'h2, 16'hbeef, d);
    core.tbl_op(1'b1, 1'b1, 1'b0, 16'h2, 16'h007a, d);
    run_op(PSF_OP_PROG2, c);
    `CHK(c >= PSF_PROG_CYC && c <= PSF_PROG_CYC + 2, 1'b1)
    for (int i = 0; i < 8; i++) begin
      core.tbl_op(1'b0, rv[i][33], rv[i][32], rv[i][31:16], 16'h0, d);
      `CHK(d, rv[i][15:0])
    end
    core.win_op(1'b1, 24'h0, d);
    core.win_op(1'b0, 24'h0, d);
    `CHK(d, 16'h1234)
    core.win_op(1'b0, 24'h2, d);
    `CHK(d, 16'hbeef)
    wr(PSF_OFS_TABLE_PAGE_REGISTER, 32'h80);
    @(negedge clk_sys);
    `CHK(tbl_cfg, 1'b1)
    wr(PSF_OFS_TABLE_PAGE_REGISTER, 32'h7f);
    @(negedge clk_sys);
    `CHK(tbl_cfg, 1'b0)
    $display("test flash done");
  endtask
  task automatic stop_test;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_refuse;
    t_flash;
    stop_test;
  end
  // About 2000 cycles are needed; allow ten times that
  initial begin
    #400000;
    bad_count++;
    stop_test;
  end
endmodule
bind psf_flash_seq psf_flash_seq_checker chk (.clk_sys(clk_sys), .rst(rst),
  .hreadyout(hreadyout), .tbl_req(tbl_req), .tbl_write(tbl_write), .tbl_rdata(tbl_rdata),
  .win_req(win_req), .win_write(win_write), .win_rdata(win_rdata), .win_err(win_err),
  .core_stall(core_stall));
